/* File: ulc_compare.sv */
// less-than-level unsigned compare with hysteresis and enable
module ulc_compare
	import ulc_pkg::*;
(
	input wire logic CLOCK_IN,
	input wire logic SYS_RST_IN,
	input wire logic [WORD_W-1:0] OPER_WORD_IN,
	input wire logic [WORD_W-1:0] COMPARE_LEVEL_IN,
	input wire logic [WORD_W-1:0] MARGIN_IN,
	input wire logic [3:0] EN_MODE_IN,
	input wire logic [1:0] EN_SRC_SEL_IN,
	input wire logic EN_ISLAND_IN,
	input wire logic EN_VIRTUAL_IN,
	input wire logic EN_MASTER_IN,
	input wire logic MASTER_CH_BIT_IN,
	input wire logic CH_DEDICATED_IN,
	output logic RESULT_OUT,
	output logic CHANNEL_OUT,
	output logic MASTER_BIT_OUT,
	output logic ENABLED_OUT
);
	logic [WORD_W-1:0] word_ff, nxt_word;
	logic [WORD_W-1:0] level_ff, nxt_level;
	logic [WORD_W-1:0] margin_ff, nxt_margin;
	logic [1:0] isl_sync_ff, nxt_isl_sync;
	logic result_ff, nxt_result;
	logic chan_ff, nxt_chan;
	logic mbit_ff, nxt_mbit;
	logic en_bool;
	logic enabled;
	logic below;
	logic above;
	ulc_en_mode_t mode;

	// island pin passes two flip-flops before use
	always_comb begin
		nxt_isl_sync = {isl_sync_ff[0], EN_ISLAND_IN};
	end

	// boolean enable source pick
	always_comb begin
		unique case (EN_SRC_SEL_IN)
			SRC_ISLAND: en_bool = isl_sync_ff[1];
			SRC_VIRTUAL: en_bool = EN_VIRTUAL_IN;
			SRC_MASTER: en_bool = EN_MASTER_IN;
			default: en_bool = 1'h0;
		endcase
	end

	// enable decode; illegal mode codes count as disabled
	always_comb begin
		mode = ulc_en_mode_t'(EN_MODE_IN);
		unique case (mode)
			ULC_EN_BOOL: enabled = en_bool;
			ULC_EN_ALWAYS_ON: enabled = 1'h1;
			ULC_EN_ALWAYS_OFF: enabled = 1'h0;
			default: enabled = 1'h0;
		endcase
	end

	// inputs captured every cycle, enabled or not
	always_comb begin
		nxt_word = OPER_WORD_IN;
		nxt_level = COMPARE_LEVEL_IN;
		nxt_margin = MARGIN_IN;
	end

	// classification of the latest captured set
	ulc_band u_band (
		.value_in(word_ff),
		.level_in(level_ff),
		.margin_in(margin_ff),
		.below_out(below),
		.above_out(above)
	);

	// hysteresis result, frozen while disabled
	always_comb begin
		nxt_result = result_ff;
		if (enabled) begin
			if (below) begin
				nxt_result = OUT_BELOW;
			end else if (above) begin
				nxt_result = OUT_ABOVE;
			end
		end
	end

	// dedicated channel follows only the block; master bit still readable
	always_comb begin
		nxt_chan = CH_DEDICATED_IN ? nxt_result : MASTER_CH_BIT_IN;
		nxt_mbit = MASTER_CH_BIT_IN;
	end

	// state registers
	always_ff @(posedge CLOCK_IN or posedge SYS_RST_IN) begin
		if (SYS_RST_IN) begin
			word_ff <= '0;
			level_ff <= '0;
			margin_ff <= '0;
			isl_sync_ff <= 2'h0;
			result_ff <= RESULT_RST;
			chan_ff <= RESULT_RST;
			mbit_ff <= 1'h0;
		end else begin
			word_ff <= nxt_word;
			level_ff <= nxt_level;
			margin_ff <= nxt_margin;
			isl_sync_ff <= nxt_isl_sync;
			result_ff <= nxt_result;
			chan_ff <= nxt_chan;
			mbit_ff <= nxt_mbit;
		end
	end

	// output drive; result may feed a second stage word input
	always_comb begin
		RESULT_OUT = result_ff;
		CHANNEL_OUT = chan_ff;
		MASTER_BIT_OUT = mbit_ff;
		ENABLED_OUT = enabled;
	end

	a_below_sets: assert property (@(posedge CLOCK_IN) disable iff (SYS_RST_IN)
		enabled && below |=> result_ff)
		else $error("below band did not set output");

	a_above_clears: assert property (@(posedge CLOCK_IN) disable iff (SYS_RST_IN)
		enabled && above |=> !result_ff)
		else $error("above band did not clear output");

	a_band_holds: assert property (@(posedge CLOCK_IN) disable iff (SYS_RST_IN)
		enabled && !below && !above |=> $stable(result_ff))
		else $error("output moved inside band");

	a_off_freezes: assert property (@(posedge CLOCK_IN) disable iff (SYS_RST_IN)
		!enabled |=> $stable(result_ff))
		else $error("output moved while disabled");

	a_capture_runs: assert property (@(posedge CLOCK_IN) disable iff (SYS_RST_IN)
		1'h1 |=> word_ff == $past(OPER_WORD_IN))
		else $error("input not captured");

	a_force_modes: assert property (@(posedge CLOCK_IN) disable iff (SYS_RST_IN)
		(EN_MODE_IN == 4'h2 |-> enabled) and (EN_MODE_IN == 4'h4 |-> !enabled))
		else $error("constant enable mode ignored");

	a_reenable_now: assert property (@(posedge CLOCK_IN) disable iff (SYS_RST_IN)
		!enabled ##1 (enabled && below) |=> result_ff)
		else $error("re-enable evaluation delayed");

	a_chan_follows: assert property (@(posedge CLOCK_IN) disable iff (SYS_RST_IN)
		CH_DEDICATED_IN |=> CHANNEL_OUT == result_ff)
		else $error("dedicated channel not following block");

	a_wide_edge: assert property (@(posedge CLOCK_IN) disable iff (SYS_RST_IN)
		enabled && word_ff == 16'hffff && level_ff == 16'hffff && margin_ff != 16'h0000
		|=> $stable(result_ff))
		else $error("level plus margin wrapped");

	// result, channel and master bit outputs low at the first edge after reset
	a_reset_low: assert property (@(posedge CLOCK_IN)
		$fell(SYS_RST_IN) |-> !result_ff && !chan_ff && !mbit_ff)
		else $error("outputs not low after reset");

	// level taken every cycle
	a_level_capture: assert property (@(posedge CLOCK_IN) disable iff (SYS_RST_IN)
		1'h1 |=> level_ff == $past(COMPARE_LEVEL_IN))
		else $error("level not captured");

	// margin taken every cycle
	a_margin_capture: assert property (@(posedge CLOCK_IN) disable iff (SYS_RST_IN)
		1'h1 |=> margin_ff == $past(MARGIN_IN))
		else $error("margin not captured");

	// master bit copied one cycle later
	a_mbit_copy: assert property (@(posedge CLOCK_IN) disable iff (SYS_RST_IN)
		1'h1 |=> mbit_ff == $past(MASTER_CH_BIT_IN))
		else $error("master bit not copied");

	// free channel passes the master bit
	a_chan_master: assert property (@(posedge CLOCK_IN) disable iff (SYS_RST_IN)
		!CH_DEDICATED_IN |=> chan_ff == $past(MASTER_CH_BIT_IN))
		else $error("free channel not passing master bit");

	// below and above never both true
	a_band_exclusive: assert property (@(posedge CLOCK_IN) disable iff (SYS_RST_IN)
		!(below && above))
		else $error("band classes overlap");

	// boolean mode follows the picked source
	a_bool_follows: assert property (@(posedge CLOCK_IN) disable iff (SYS_RST_IN)
		EN_MODE_IN == 4'h1 |-> enabled == en_bool)
		else $error("boolean enable not followed");

	// unknown mode codes disable the block
	a_bad_mode_off: assert property (@(posedge CLOCK_IN) disable iff (SYS_RST_IN)
		EN_MODE_IN != 4'h1 && EN_MODE_IN != 4'h2 && EN_MODE_IN != 4'h4 |-> !enabled)
		else $error("illegal mode enabled block");

	// virtual source used directly
	a_src_virtual: assert property (@(posedge CLOCK_IN) disable iff (SYS_RST_IN)
		EN_MODE_IN == 4'h1 && EN_SRC_SEL_IN == 2'h1 |-> enabled == EN_VIRTUAL_IN)
		else $error("virtual enable not followed");

	// master source used directly
	a_src_master: assert property (@(posedge CLOCK_IN) disable iff (SYS_RST_IN)
		EN_MODE_IN == 4'h1 && EN_SRC_SEL_IN == 2'h2 |-> enabled == EN_MASTER_IN)
		else $error("master enable not followed");

	// island source read after the second flop
	a_src_island: assert property (@(posedge CLOCK_IN) disable iff (SYS_RST_IN)
		EN_MODE_IN == 4'h1 && EN_SRC_SEL_IN == 2'h0 |-> enabled == isl_sync_ff[1])
		else $error("island enable not followed");

	// unused source code reads as false
	a_src_none: assert property (@(posedge CLOCK_IN) disable iff (SYS_RST_IN)
		EN_MODE_IN == 4'h1 && EN_SRC_SEL_IN == 2'h3 |-> !enabled)
		else $error("unused source enabled block");

	// synchroniser shifts one stage per cycle
	a_sync_chain: assert property (@(posedge CLOCK_IN) disable iff (SYS_RST_IN)
		1'h1 |=> isl_sync_ff[1] == $past(isl_sync_ff[0]))
		else $error("island synchroniser broken");

	// high half of the range counts as large
	a_sign_magnitude: assert property (@(posedge CLOCK_IN) disable iff (SYS_RST_IN)
		enabled && word_ff[15] && level_ff < 16'h4000 && margin_ff < 16'h4000 |=> !result_ff)
		else $error("top bit treated as sign");

	// lower edge under zero leaves nothing below
	a_low_never_below: assert property (@(posedge CLOCK_IN) disable iff (SYS_RST_IN)
		level_ff < margin_ff |-> !below)
		else $error("wrapped lower edge");

	// upper edge over the range leaves nothing above
	a_top_never_above: assert property (@(posedge CLOCK_IN) disable iff (SYS_RST_IN)
		level_ff > 16'hffff - margin_ff |-> !above)
		else $error("wrapped upper edge");

	// result only moves after an enabled cycle
	a_move_enabled: assert property (@(posedge CLOCK_IN) disable iff (SYS_RST_IN)
		$changed(result_ff) |-> $past(enabled))
		else $error("result moved without enable");

	// a rise needs the input below the band
	a_rise_cause: assert property (@(posedge CLOCK_IN) disable iff (SYS_RST_IN)
		$rose(result_ff) |-> $past(below))
		else $error("result rose without cause");

	// a fall needs the input above the band
	a_fall_cause: assert property (@(posedge CLOCK_IN) disable iff (SYS_RST_IN)
		$fell(result_ff) |-> $past(above))
		else $error("result fell without cause");

	// result port mirrors its register
	a_out_mirror: assert property (@(posedge CLOCK_IN) disable iff (SYS_RST_IN)
		RESULT_OUT == result_ff)
		else $error("result port differs");

	// enable port mirrors the decode
	a_en_mirror: assert property (@(posedge CLOCK_IN) disable iff (SYS_RST_IN)
		ENABLED_OUT == enabled)
		else $error("enable port differs");

	// channel port mirrors its register
	a_chan_mirror: assert property (@(posedge CLOCK_IN) disable iff (SYS_RST_IN)
		CHANNEL_OUT == chan_ff)
		else $error("channel port differs");

	// master copy port mirrors its register
	a_mbit_mirror: assert property (@(posedge CLOCK_IN) disable iff (SYS_RST_IN)
		MASTER_BIT_OUT == mbit_ff)
		else $error("master copy port differs");
endmodule : ulc_compare

/* File: ulc_pkg.sv */
// shared constants for the unsigned below-level hysteresis compare block
package ulc_pkg;
	localparam int WORD_W = 16; // operational input width, 0..65535
	localparam int WIDE_W = 17; // one bit of headroom for level plus margin
	localparam logic RESULT_RST = 1'h0; // output value after reset
	localparam logic OUT_BELOW = 1'h1; // output when input sits under the band
	localparam logic OUT_ABOVE = 1'h0; // output when input sits over the band
	// enable mode selection
	typedef enum logic [3:0] {
		ULC_EN_BOOL = 4'h1,
		ULC_EN_ALWAYS_ON = 4'h2,
		ULC_EN_ALWAYS_OFF = 4'h4,
		ULC_EN_RSVD = 4'h8
	} ulc_en_mode_t;
	// enable boolean source selection
	localparam logic [1:0] SRC_ISLAND = 2'h0;
	localparam logic [1:0] SRC_VIRTUAL = 2'h1;
	localparam logic [1:0] SRC_MASTER = 2'h2;
endpackage : ulc_pkg

/* File: ulc_band.sv */
// band classifier: compares a word against level minus and plus margin
module ulc_band
	import ulc_pkg::*;
(
	input wire logic [WORD_W-1:0] value_in,
	input wire logic [WORD_W-1:0] level_in,
	input wire logic [WORD_W-1:0] margin_in,
	output logic below_out,
	output logic above_out
);
	logic [WIDE_W-1:0] lo_edge;
	logic [WIDE_W-1:0] hi_edge;
	logic [WIDE_W-1:0] val_w;
	// widened edges so level plus margin cannot wrap
	always_comb begin
		val_w = {1'h0, value_in}; // top bit is magnitude, never sign
		lo_edge = {1'h0, level_in} - {1'h0, margin_in};
		hi_edge = {1'h0, level_in} + {1'h0, margin_in};
		// a negative lower edge leaves nothing strictly below it
		below_out = !lo_edge[WIDE_W-1] && (val_w < lo_edge);
		above_out = (val_w >= hi_edge);
	end
endmodule : ulc_band

/* File: ulc_src_model.sv */
// far-side source model: word source and one boolean source bit
module ulc_src_model(
	input wire logic clk_in,
	input wire logic [15:0] word_req_in,
	input wire logic bit_req_in,
	output logic [15:0] word_out = 16'h0000,
	output logic bit_out = 1'h0
);
	timeunit 1ns;
	timeprecision 100ps;
	// sources change just after the edge
	always @(posedge clk_in) begin
		word_out <= #1 word_req_in;
		bit_out <= #1 bit_req_in;
	end
endmodule : ulc_src_model

/* File: ulc_compare_tb_top.sv */
// testbench for the below-level hysteresis compare block
module ulc_compare_tb_top
	import ulc_pkg::*;
;
	timeunit 1ns;
	timeprecision 100ps;
	logic clk = 1'h0, rst = 1'h1, bit_req = 1'h0, en_bit, mbit = 1'h0, ded = 1'h1;
	logic res, chan, mcopy, en;
	logic [15:0] word_req = 16'h0000, level = 16'h0000, margin = 16'h0000, word;
	logic [3:0] mode = 4'h2;
	logic [1:0] sel = 2'h1;
	int fails = 0, n_checks = 0;
	ulc_src_model i_ulc_src_model(.clk_in(clk), .word_req_in(word_req),
		.bit_req_in(bit_req), .word_out(word), .bit_out(en_bit));
	ulc_compare i_ulc_compare(.CLOCK_IN(clk), .SYS_RST_IN(rst), .OPER_WORD_IN(word),
		.COMPARE_LEVEL_IN(level), .MARGIN_IN(margin), .EN_MODE_IN(mode),
		.EN_SRC_SEL_IN(sel), .EN_ISLAND_IN(en_bit), .EN_VIRTUAL_IN(en_bit),
		.EN_MASTER_IN(en_bit), .MASTER_CH_BIT_IN(mbit), .CH_DEDICATED_IN(ded),
		.RESULT_OUT(res), .CHANNEL_OUT(chan), .MASTER_BIT_OUT(mcopy), .ENABLED_OUT(en));
	// clock and watchdog
	initial forever #2.5 clk = ~clk;
	initial begin
		#5000;
		fails++;
		stop_test();
	end
	task automatic stop_test;
		if (fails == 0 && n_checks > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask : stop_test
	task automatic chk(input string name, input logic e, input logic s);
		n_checks++;
		if (s !== e) begin
			fails++;
			$display("[FAIL] %s expected %b seen %b", name, e, s);
		end
	endtask : chk
	// drive a word, let it settle through sync and pipeline, then compare
	task automatic step(input logic [15:0] w, input logic e);
		word_req = w;
		repeat (5) @(posedge clk);
		#1;
		chk("result", e, res);
	endtask : step
	// band edges around level 48000 with margin 32
	task automatic t_band;
		level = 16'hbb80;
		margin = 16'h0020;
		step(16'h0064, 1'h1);
		step(16'hbb60, 1'h1);
		step(16'hbba0, 1'h0);
		step(16'hbb60, 1'h0);
		step(16'hbb5f, 1'h1);
		step(16'hffff, 1'h0);
	endtask : t_band
	// top bit counts as magnitude
	task automatic t_sign;
		level = 16'h0064;
		margin = 16'h0000;
		step(16'h0000, 1'h1);
		step(16'h8000, 1'h0);
	endtask : t_sign
	// freeze while disabled, act on re-enable within one five-edge step
	task automatic t_enable(input logic [1:0] s);
		mode = ULC_EN_BOOL;
		sel = s;
		bit_req = 1'h0;
		step(16'h8000, 1'h0);
		chk("enabled", 1'h0, en);
		step(16'h0000, 1'h0);
		bit_req = 1'h1;
		step(16'h0000, 1'h1);
		step(16'h8000, 1'h0);
	endtask : t_enable
	// constant modes, then channel ownership
	task automatic t_channel;
		mode = ULC_EN_ALWAYS_OFF;
		step(16'h0000, 1'h0);
		mode = ULC_EN_ALWAYS_ON;
		step(16'h0000, 1'h1);
		chk("channel", 1'h1, chan);
		ded = 1'h0;
		mbit = 1'h1;
		step(16'h0000, 1'h1);
		chk("master copy", 1'h1, mcopy);
		chk("channel", 1'h1, chan);
		mbit = 1'h0;
		step(16'h0000, 1'h1);
		chk("channel", 1'h0, chan);
	endtask : t_channel
	// main sequence
	initial begin
		repeat (12) @(posedge clk);
		#1;
		rst = 1'h0;
		chk("reset result", 1'h0, res);
		t_band();
		t_sign();
		for (int s = 0; s < 3; s++) t_enable(2'(s));
		t_channel();
		stop_test();
	end
endmodule : ulc_compare_tb_top
